// *** verilog/ptsc_consts.vh ***
// Purpose: shared constants of the per-point edge timestamp capture block
// Assumes: 20 MHz module clock, 64-bit shared system time in microseconds
// Notes:   definitions only
`ifndef PTSC_CONSTS_VH
`define PTSC_CONSTS_VH

`define PTSC_POINTS        16
`define PTSC_TIME_W        64
`define PTSC_CLK_HZ        20000000
`define PTSC_RES_US        25
// cycles per timestamp tick
`define PTSC_RES_CYC       (`PTSC_RES_US * (`PTSC_CLK_HZ / 1000000))
`define PTSC_RES_CNT_W     10

// register index map (word addresses)
`define PTSC_A_W           6
`define PTSC_R_CTRL        6'h00
`define PTSC_R_CAP_RISE    6'h01
`define PTSC_R_CAP_FALL    6'h02
`define PTSC_R_INPUTS      6'h03
`define PTSC_R_VALID_RISE  6'h04
`define PTSC_R_VALID_FALL  6'h05
`define PTSC_R_MISSED      6'h06
`define PTSC_R_ACK_RISE    6'h07
`define PTSC_R_ACK_FALL    6'h08
`define PTSC_R_IRQ_STAT    6'h09
`define PTSC_R_IRQ_MASK    6'h0A
`define PTSC_R_FAULT       6'h0B
`define PTSC_R_SERIAL      6'h0C
`define PTSC_R_REVISION    6'h0D
`define PTSC_R_PRODUCT     6'h0E
`define PTSC_R_VENDOR      6'h0F
`define PTSC_R_DIAG_EVT    6'h10
`define PTSC_R_DIAG_MISS   6'h11
`define PTSC_R_DIAG_PROD   6'h12
`define PTSC_R_RPI         6'h13
`define PTSC_R_SEL         6'h14
`define PTSC_R_REC_LO      6'h15
`define PTSC_R_REC_HI      6'h16
`define PTSC_R_REC_INFO    6'h17

// control bits
`define PTSC_CTRL_HOLD     0
`define PTSC_CTRL_RUN      1
`define PTSC_CTRL_FCLR     2
`define PTSC_CTRL_RST_VAL  32'h0000_0001

// interrupt status bits
`define PTSC_IRQ_EVT       0
`define PTSC_IRQ_MISS      1
`define PTSC_IRQ_FAULT     2
`define PTSC_IRQ_PROD      3

// fault codes
`define PTSC_FLT_NONE      8'h00
`define PTSC_FLT_TIME      8'h01
`define PTSC_FLT_RPI       8'h02

// health indicator codes {red,green}
`define PTSC_LED_OFF       2'h0
`define PTSC_LED_GREEN     2'h1
`define PTSC_LED_RED       2'h2

`define PTSC_RPI_RST       32'h0000_0000
`define PTSC_RPI_UNIT_CYC  20000

`endif

// *** verilog/ptsc_sync.v ***
// Purpose: two-flop synchroniser for the field inputs
// Assumes: inputs asynchronous to sys_clk
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module ptsc_sync #(
  parameter WIDTH = 16
) (
  input  wire             sys_clk,
  input  wire             sys_rst,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] stage1;

  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stage1 <= {WIDTH{1'b0}};
      dout   <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule // ptsc_sync
`default_nettype wire

// *** verilog/ptsc_stamp_mem.v ***
// Purpose: timestamp slot memory, two slots per point
// Assumes: one write and one read port, registered read data
// Notes:   address = {point, direction}
`timescale 1ns/1ps
`default_nettype none
module ptsc_stamp_mem #(
  parameter AW = 5,
  parameter DW = 64
) (
  input  wire          sys_clk,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge sys_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    rd_data <= mem[rd_addr];
  end
endmodule // ptsc_stamp_mem
`default_nettype wire

// *** verilog/ptsc_capture.v ***
// Purpose: per-point edge timestamp capture with unsolicited data production
// Assumes: shared_system_time arrives from same-clock backplane logic
// Notes:   filter qualification compares input samples taken on two successive ticks
//
// Overview of operation
// - two slots per point, rise and fall
// - enabled transition records shared system time
// - disabled points or directions are not stamped
// - timestamp resolution of 25 us
// - produce on qualification and every interval
// - send whole input image after capture
// - push data without waiting for poll
// - yellow indicator per point shows input
// - red/green health shows communication and module
// - fault on indicator and readable code
// - answer serial, revision, product, vendor, counters
// - hold keeps unacknowledged record from overwrite
// - dropped transition sets missed event flag
`timescale 1ns/1ps
`default_nettype none
`include "ptsc_consts.vh"
module ptsc_capture #(
  parameter        NPTS        = `PTSC_POINTS,
  parameter        TW          = `PTSC_TIME_W,
  parameter        RES_CYC     = `PTSC_RES_CYC,
  parameter [31:0] SERIAL_ID   = 32'h0000_1234,
  parameter [31:0] REVISION_ID = 32'h0000_0101,
  parameter [31:0] PRODUCT_ID  = 32'h0000_0ABC,
  parameter [31:0] VENDOR_ID   = 32'h0000_0055
) (
  input  wire                 sys_clk,
  input  wire                 sys_rst,
  input  wire [NPTS-1:0]      field_in,
  input  wire [TW-1:0]        shared_system_time,
  input  wire                 per_point_timestamp_mode,
  input  wire                 link_up,
  input  wire [`PTSC_A_W-1:0] reg_addr,
  input  wire [31:0]          reg_wdata,
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  output reg  [31:0]          reg_rdata,
  output reg                  produce_strobe,
  output reg  [NPTS-1:0]      produce_inputs,
  output reg  [NPTS-1:0]      produce_valid_rise,
  output reg  [NPTS-1:0]      produce_valid_fall,
  output reg  [NPTS-1:0]      produce_missed,
  output reg  [NPTS-1:0]      point_state_indicator,
  output reg                  module_health_red,
  output reg                  module_health_green,
  output reg                  irq
);
  // identity values above are arbitrary

  // ----------------------------------------
  // input synchronisation and qualification
  // ----------------------------------------
  wire [NPTS-1:0] in_sync;
  reg  [NPTS-1:0] in_prev;
  reg  [NPTS-1:0] in_qual;
  reg  [`PTSC_RES_CNT_W-1:0] tick_cnt;
  wire            tick = (tick_cnt == RES_CYC - 1);

  ptsc_sync #(.WIDTH(NPTS)) u_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .din     (field_in),
    .dout    (in_sync)
  );

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [31:0]     ctrl;
  reg  [NPTS-1:0] cap_rise;
  reg  [NPTS-1:0] cap_fall;
  reg  [NPTS-1:0] valid_rise;
  reg  [NPTS-1:0] valid_fall;
  reg  [NPTS-1:0] missed_event_flag;
  reg  [3:0]      irq_stat;
  reg  [3:0]      irq_mask;
  reg  [7:0]      fault_code;
  reg  [31:0]     diag_evt;
  reg  [31:0]     diag_miss;
  reg  [31:0]     diag_prod;
  reg  [31:0]     requested_packet_interval;
  reg  [4:0]      rec_sel;
  reg  [31:0]     rpi_cnt;
  reg  [15:0]     rpi_unit;
  reg  [TW-1:0]   time_prev;

  wire timestamp_hold = ctrl[`PTSC_CTRL_HOLD];
  wire run            = ctrl[`PTSC_CTRL_RUN];

  // rising and falling transitions of the qualified image
  wire [NPTS-1:0] edge_rise = tick ? ( in_prev & ~in_qual) : {NPTS{1'b0}};
  wire [NPTS-1:0] edge_fall = tick ? (~in_prev &  in_qual) : {NPTS{1'b0}};
  wire            active    = run & per_point_timestamp_mode;

  wire [NPTS-1:0] req_rise = edge_rise & cap_rise & {NPTS{active}};
  wire [NPTS-1:0] req_fall = edge_fall & cap_fall & {NPTS{active}};
  wire [NPTS-1:0] blk_rise = req_rise & valid_rise & {NPTS{timestamp_hold}};
  wire [NPTS-1:0] blk_fall = req_fall & valid_fall & {NPTS{timestamp_hold}};
  wire [NPTS-1:0] take_rise = req_rise & ~blk_rise;
  wire [NPTS-1:0] take_fall = req_fall & ~blk_fall;

  wire wr_ack_r = reg_wr & (reg_addr == `PTSC_R_ACK_RISE);
  wire wr_ack_f = reg_wr & (reg_addr == `PTSC_R_ACK_FALL);
  wire wr_miss  = reg_wr & (reg_addr == `PTSC_R_MISSED);
  wire wr_istat = reg_wr & (reg_addr == `PTSC_R_IRQ_STAT);
  wire wr_ctrl  = reg_wr & (reg_addr == `PTSC_R_CTRL);

  // ----------------------------------------
  // serialised slot writer: one capture per cycle into memory
  // ----------------------------------------
  reg  [2*NPTS-1:0] wpend;
  reg  [TW-1:0]     wtime [0:2*NPTS-1];
  reg  [4:0]        wsel;
  reg               wen;
  integer           i;

  function [4:0] first_set;
    input [2*NPTS-1:0] v;
    integer k;
    begin
      first_set = 5'h00;
      for (k = 2*NPTS-1; k >= 0; k = k - 1)
        if (v[k])
          first_set = k[4:0];
    end
  endfunction

  function [31:0] sat_inc;
    input [31:0] v;
    begin
      sat_inc = (v == 32'hFFFF_FFFF) ? v : v + 32'h0000_0001;
    end
  endfunction

  wire [TW-1:0] mem_rdata;

  // slot address is {point, direction}: direction 0 rise, 1 fall
  ptsc_stamp_mem #(.AW(5), .DW(TW)) u_mem (
    .sys_clk (sys_clk),
    .wr_en   (wen),
    .wr_addr (wsel),
    .wr_data (wtime[wsel]),
    .rd_addr (rec_sel),
    .rd_data (mem_rdata)
  );

  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wpend <= {2*NPTS{1'b0}};
      wsel  <= 5'h00;
      wen   <= 1'b0;
      for (i = 0; i < 2*NPTS; i = i + 1)
        wtime[i] <= {TW{1'b0}};
    end
    else
    begin
      wen  <= |wpend;
      wsel <= first_set(wpend);
      for (i = 0; i < NPTS; i = i + 1)
      begin
        if (take_rise[i])
          wtime[2*i] <= shared_system_time;
        if (take_fall[i])
          wtime[2*i+1] <= shared_system_time;
      end
      wpend <= (wpend & ~({{(2*NPTS-1){1'b0}}, 1'b1} << first_set(wpend)))
             | interleave(take_rise, take_fall);
    end
  end

  function [2*NPTS-1:0] interleave;
    input [NPTS-1:0] r;
    input [NPTS-1:0] f;
    integer k;
    begin
      interleave = {2*NPTS{1'b0}};
      for (k = 0; k < NPTS; k = k + 1)
      begin
        interleave[2*k]   = r[k];
        interleave[2*k+1] = f[k];
      end
    end
  endfunction

  // ----------------------------------------
  // qualification tick, slot state, production
  // ----------------------------------------
  wire rpi_due  = (requested_packet_interval != 32'h0000_0000) &&
                  (rpi_cnt >= requested_packet_interval);
  wire evt_now  = |(take_rise | take_fall);
  wire time_bad = tick & (shared_system_time == time_prev);

  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tick_cnt  <= {`PTSC_RES_CNT_W{1'b0}};
      in_qual   <= {NPTS{1'b0}};
      in_prev   <= {NPTS{1'b0}};
      time_prev <= {TW{1'b0}};
    end
    else
    begin
      tick_cnt <= tick ? {`PTSC_RES_CNT_W{1'b0}} : tick_cnt + 1'b1;
      if (tick)
      begin
        in_prev   <= in_sync;
        in_qual   <= in_prev;
        time_prev <= shared_system_time;
      end
    end
  end

  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      valid_rise         <= {NPTS{1'b0}};
      valid_fall         <= {NPTS{1'b0}};
      missed_event_flag  <= {NPTS{1'b0}};
      rpi_cnt            <= 32'h0000_0000;
      rpi_unit           <= 16'h0000;
      produce_strobe     <= 1'b0;
      produce_inputs     <= {NPTS{1'b0}};
      produce_valid_rise <= {NPTS{1'b0}};
      produce_valid_fall <= {NPTS{1'b0}};
      produce_missed     <= {NPTS{1'b0}};
      diag_evt           <= 32'h0000_0000;
      diag_miss          <= 32'h0000_0000;
      diag_prod          <= 32'h0000_0000;
      fault_code         <= `PTSC_FLT_NONE;
    end
    else
    begin
      // capture sets win over acknowledge clears
      valid_rise <= (valid_rise & ~(reg_wdata[NPTS-1:0] & {NPTS{wr_ack_r}})) | take_rise;
      valid_fall <= (valid_fall & ~(reg_wdata[NPTS-1:0] & {NPTS{wr_ack_f}})) | take_fall;
      missed_event_flag <= (missed_event_flag & ~(reg_wdata[NPTS-1:0] & {NPTS{wr_miss}}))
                         | blk_rise | blk_fall;
      if (evt_now)
        diag_evt <= sat_inc(diag_evt);
      if (|(blk_rise | blk_fall))
        diag_miss <= sat_inc(diag_miss);
      // interval timer in 1 ms units
      if (rpi_unit == `PTSC_RPI_UNIT_CYC - 1)
      begin
        rpi_unit <= 16'h0000;
        rpi_cnt  <= sat_inc(rpi_cnt);
      end
      else
        rpi_unit <= rpi_unit + 16'h0001;
      produce_strobe <= 1'b0;
      if (active & link_up & (evt_now | rpi_due))
      begin
        produce_strobe     <= 1'b1;
        produce_inputs     <= in_prev;
        produce_valid_rise <= valid_rise | take_rise;
        produce_valid_fall <= valid_fall | take_fall;
        produce_missed     <= missed_event_flag | blk_rise | blk_fall;
        rpi_cnt            <= 32'h0000_0000;
        rpi_unit           <= 16'h0000;
        diag_prod          <= sat_inc(diag_prod);
      end
      if (time_bad & active)
        fault_code <= `PTSC_FLT_TIME;
      else if (wr_ctrl & reg_wdata[`PTSC_CTRL_FCLR])
        fault_code <= `PTSC_FLT_NONE;
    end
  end

  // ----------------------------------------
  // register port, interrupts, indicators
  // ----------------------------------------
  wire [3:0] irq_evt = {produce_strobe, (fault_code != `PTSC_FLT_NONE), |(blk_rise | blk_fall), evt_now};

  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl                      <= `PTSC_CTRL_RST_VAL;
      cap_rise                  <= {NPTS{1'b0}};
      cap_fall                  <= {NPTS{1'b0}};
      irq_mask                  <= 4'h0;
      irq_stat                  <= 4'h0;
      requested_packet_interval <= `PTSC_RPI_RST;
      rec_sel                   <= 5'h00;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= {29'h0000_0000, 1'b0, reg_wdata[`PTSC_CTRL_RUN], reg_wdata[`PTSC_CTRL_HOLD]};
      if (reg_wr & (reg_addr == `PTSC_R_CAP_RISE))
        cap_rise <= reg_wdata[NPTS-1:0];
      if (reg_wr & (reg_addr == `PTSC_R_CAP_FALL))
        cap_fall <= reg_wdata[NPTS-1:0];
      if (reg_wr & (reg_addr == `PTSC_R_IRQ_MASK))
        irq_mask <= reg_wdata[3:0];
      if (reg_wr & (reg_addr == `PTSC_R_RPI))
        requested_packet_interval <= reg_wdata;
      if (reg_wr & (reg_addr == `PTSC_R_SEL))
        rec_sel <= reg_wdata[4:0];
      irq_stat <= (irq_stat & ~(wr_istat ? reg_wdata[3:0] : 4'h0)) | irq_evt;
    end
  end

  reg [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      `PTSC_R_CTRL:       rd_mux = ctrl;
      `PTSC_R_CAP_RISE:   rd_mux = {16'h0000, cap_rise};
      `PTSC_R_CAP_FALL:   rd_mux = {16'h0000, cap_fall};
      `PTSC_R_INPUTS:     rd_mux = {16'h0000, in_qual};
      `PTSC_R_VALID_RISE: rd_mux = {16'h0000, valid_rise};
      `PTSC_R_VALID_FALL: rd_mux = {16'h0000, valid_fall};
      `PTSC_R_MISSED:     rd_mux = {16'h0000, missed_event_flag};
      `PTSC_R_IRQ_STAT:   rd_mux = {28'h000_0000, irq_stat};
      `PTSC_R_IRQ_MASK:   rd_mux = {28'h000_0000, irq_mask};
      `PTSC_R_FAULT:      rd_mux = {24'h00_0000, fault_code};
      `PTSC_R_SERIAL:     rd_mux = SERIAL_ID;
      `PTSC_R_REVISION:   rd_mux = REVISION_ID;
      `PTSC_R_PRODUCT:    rd_mux = PRODUCT_ID;
      `PTSC_R_VENDOR:     rd_mux = VENDOR_ID;
      `PTSC_R_DIAG_EVT:   rd_mux = diag_evt;
      `PTSC_R_DIAG_MISS:  rd_mux = diag_miss;
      `PTSC_R_DIAG_PROD:  rd_mux = diag_prod;
      `PTSC_R_RPI:        rd_mux = requested_packet_interval;
      `PTSC_R_SEL:        rd_mux = {27'h000_0000, rec_sel};
      `PTSC_R_REC_LO:     rd_mux = mem_rdata[31:0];
      `PTSC_R_REC_HI:     rd_mux = mem_rdata[TW-1:32];
      `PTSC_R_REC_INFO:   rd_mux = {16'h0000, 6'h00,
                                    (rec_sel[0] ? valid_fall[rec_sel[4:1]] : valid_rise[rec_sel[4:1]]),
                                    rec_sel[0], 4'h0, rec_sel[4:1]};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reg_rdata             <= 32'h0000_0000;
      irq                   <= 1'b0;
      point_state_indicator <= {NPTS{1'b0}};
      module_health_red     <= 1'b0;
      module_health_green   <= 1'b0;
    end
    else
    begin
      reg_rdata             <= reg_rd ? rd_mux : 32'h0000_0000;
      irq                   <= |(irq_stat & irq_mask);
      point_state_indicator <= in_sync;
      module_health_red     <= (fault_code != `PTSC_FLT_NONE);
      module_health_green   <= (fault_code == `PTSC_FLT_NONE) & active & link_up;
    end
  end
endmodule // ptsc_capture
`default_nettype wire

// *** tb/ptsc_capture_checker.sv ***
// Purpose: port-level assertions for ptsc_capture
// Assumes: one clock domain, async active-high reset
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
`include "ptsc_consts.vh"
module ptsc_capture_checker #(
  parameter        NPTS      = 16,
  parameter [31:0] VENDOR_ID = 32'h0000_0055
) (
  input wire logic                 sys_clk,
  input wire logic                 sys_rst,
  input wire logic [NPTS-1:0]      field_in,
  input wire logic                 per_point_timestamp_mode,
  input wire logic                 link_up,
  input wire logic [`PTSC_A_W-1:0] reg_addr,
  input wire logic                 reg_rd,
  input wire logic [31:0]          reg_rdata,
  input wire logic                 produce_strobe,
  input wire logic [NPTS-1:0]      produce_inputs,
  input wire logic [NPTS-1:0]      produce_valid_rise,
  input wire logic [NPTS-1:0]      produce_valid_fall,
  input wire logic [NPTS-1:0]      produce_missed,
  input wire logic [NPTS-1:0]      point_state_indicator,
  input wire logic                 module_health_red,
  input wire logic                 module_health_green,
  input wire logic                 irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("stray read data");
  a_vendor_id_read: assert property (reg_rd && reg_addr == `PTSC_R_VENDOR |=> reg_rdata == VENDOR_ID)
    else $error("vendor read wrong");
  a_unmapped_reads_zero: assert property (reg_rd && reg_addr > 6'h17 |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_strobe_one_cycle: assert property (produce_strobe |=> !produce_strobe)
    else $error("strobe too long");
  a_image_held: assert property (!produce_strobe |-> $stable(produce_inputs) && $stable(produce_valid_rise)
    && $stable(produce_valid_fall) && $stable(produce_missed))
    else $error("image moved without strobe");
  a_no_push_offline: assert property (!link_up || !per_point_timestamp_mode |=> !produce_strobe)
    else $error("push while offline");
  a_health_exclusive: assert property (module_health_red |-> !module_health_green)
    else $error("red and green together");
  a_green_needs_link: assert property (!link_up [*2] |-> !module_health_green)
    else $error("green while offline");
  a_indicator_follows: assert property ($stable(field_in) [*4] |-> point_state_indicator == field_in)
    else $error("indicator lags input");
  c_push_capture: cover property (produce_strobe && |produce_valid_rise);
  c_fault_red: cover property (module_health_red);
  c_irq_high: cover property (irq);
endmodule // ptsc_capture_checker
`default_nettype wire

// *** tb/ptsc_ctrl_model.sv ***
// Purpose: owning controller model: backplane time, format, consumer
// Assumes: same clock as the capture block
// Notes:   time advances one unit a cycle unless frozen
`timescale 1ns/1ps
`default_nettype none
module ptsc_ctrl_model (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        time_freeze,
  input  wire logic        link_en,
  input  wire logic        produce_strobe,
  input  wire logic [15:0] produce_inputs,
  output var  logic [63:0] shared_system_time,
  output var  logic        per_point_timestamp_mode,
  output var  logic        link_up,
  output var  logic [15:0] seen_inputs
);
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      shared_system_time <= 64'h0000_0000_0000_0100;
      per_point_timestamp_mode <= 1'b0;
      link_up <= 1'b0;
      seen_inputs <= 16'h0000;
    end
    else
    begin
      if (!time_freeze)
        shared_system_time <= shared_system_time + 64'h1;
      // format chosen when the connection opens
      per_point_timestamp_mode <= link_en;
      link_up <= link_en;
      if (produce_strobe)
        seen_inputs <= produce_inputs;
    end
  end
endmodule // ptsc_ctrl_model
`default_nettype wire

// *** tb/ptsc_capture_test.sv ***
// Purpose: self-checking bench for ptsc_capture
// Assumes: 20 MHz clock, tick shortened to 4 cycles
// Notes:   identity values are arbitrary
`timescale 1ns/1ps
`default_nettype none
`include "ptsc_consts.vh"
module ptsc_capture_test;
  localparam [31:0] SER  = 32'h0000_0042; // arbitrary
  localparam [31:0] REV  = 32'h0000_0203; // arbitrary
  localparam [31:0] PRD  = 32'h0000_0C0D; // arbitrary
  localparam [31:0] VEND = 32'h0000_00A5; // arbitrary
  localparam int    UNIT = `PTSC_RPI_UNIT_CYC;
  logic        sys_clk     = 1'b0;
  logic        sys_rst     = 1'b1;
  logic [15:0] field_in    = 16'h0000;
  logic [5:0]  reg_addr    = 6'h00;
  logic [31:0] reg_wdata   = 32'h0000_0000;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic        time_freeze = 1'b0;
  logic        link_en     = 1'b0;
  int          bad_count   = 0;
  int          check_count = 0;
  wire logic [63:0] sst;
  wire logic        mode;
  wire logic        link_up;
  wire logic [31:0] reg_rdata;
  wire logic        produce_strobe;
  wire logic [15:0] produce_inputs;
  wire logic [15:0] produce_valid_rise;
  wire logic [15:0] produce_valid_fall;
  wire logic [15:0] produce_missed;
  wire logic [15:0] leds;
  wire logic        red;
  wire logic        green;
  wire logic        irq;
  wire logic [15:0] seen_inputs;

  always #25 sys_clk = ~sys_clk;

  ptsc_capture #(.RES_CYC(4), .SERIAL_ID(SER), .REVISION_ID(REV), .PRODUCT_ID(PRD), .VENDOR_ID(VEND)) u_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .field_in(field_in), .shared_system_time(sst),
    .per_point_timestamp_mode(mode), .link_up(link_up), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .produce_strobe(produce_strobe),
    .produce_inputs(produce_inputs), .produce_valid_rise(produce_valid_rise),
    .produce_valid_fall(produce_valid_fall), .produce_missed(produce_missed), .point_state_indicator(leds),
    .module_health_red(red), .module_health_green(green), .irq(irq));

  ptsc_ctrl_model u_ctrl (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .time_freeze(time_freeze), .link_en(link_en),
    .produce_strobe(produce_strobe), .produce_inputs(produce_inputs), .shared_system_time(sst),
    .per_point_timestamp_mode(mode), .link_up(link_up), .seen_inputs(seen_inputs));

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_rng(input string n, input logic [63:0] lo, input logic [63:0] hi, input logic [63:0] g);
    check_count++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      bad_count++;
      $display("Error %s expected %h..%h seen %h", n, lo, hi, g);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
    @(posedge sys_clk);
  endtask

  task automatic rc(input logic [5:0] a, input string n, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask

  task automatic rec(input logic [4:0] s, output logic [63:0] t, output logic [31:0] info);
    wr(`PTSC_R_SEL, {27'h0, s});
    rd(`PTSC_R_REC_LO, t[31:0]);
    rd(`PTSC_R_REC_HI, t[63:32]);
    rd(`PTSC_R_REC_INFO, info);
  endtask

  task automatic wait_prod(input int lim, output int n);
    n = lim;
    for (int i = 0; i < lim; i++)
    begin
      @(negedge sys_clk);
      if (produce_strobe === 1'b1)
      begin
        n = i;
        break;
      end
    end
    @(posedge sys_clk);
    chk("push seen", 32'h1, {31'h0, n < lim});
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    stop_test();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin : main
    logic [31:0] d;
    logic [63:0] t;
    logic [63:0] t0;
    logic [63:0] rise0;
    int          n;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    link_en <= 1'b1;
    rc(`PTSC_R_SERIAL, "serial", SER);
    rc(`PTSC_R_REVISION, "revision", REV);
    rc(`PTSC_R_PRODUCT, "product", PRD);
    rc(`PTSC_R_VENDOR, "vendor", VEND);
    rc(`PTSC_R_CTRL, "ctrl", `PTSC_CTRL_RST_VAL);
    wr(6'h3F, 32'hFFFF_FFFF);
    rc(6'h3F, "unmapped", 32'h0000_0000);
    $display("identity test done");
    wr(`PTSC_R_CAP_RISE, 32'h0000_0003);
    wr(`PTSC_R_CAP_FALL, 32'h0000_0001);
    wr(`PTSC_R_IRQ_MASK, 32'h0000_0001);
    wr(`PTSC_R_CTRL, 32'h0000_0003);
    t0 = sst;
    field_in <= 16'h0005;
    wait_prod(200, n);
    chk("rise valid", 32'h1, {16'h0, produce_valid_rise});
    chk("input image", 32'h5, {16'h0, produce_inputs});
    chk("indicator", 32'h5, {16'h0, leds});
    rec(5'd0, rise0, d);
    chk("pushed image", 32'h5, {16'h0, seen_inputs});
    chk_rng("rise time", t0, sst, rise0);
    chk("rise info", 32'h0000_0200, d);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(`PTSC_R_IRQ_STAT, 32'h0000_000F);
    wr(`PTSC_R_IRQ_MASK, 32'h0000_0000);
    rc(`PTSC_R_IRQ_STAT, "stat cleared", 32'h0);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("capture test done");
    field_in <= 16'h0004;
    wait_prod(200, n);
    chk("fall pushed", 32'h1, {16'h0, produce_valid_fall});
    field_in <= 16'h0005;
    repeat (80) @(posedge sys_clk);
    rc(`PTSC_R_MISSED, "missed", 32'h1);
    rc(`PTSC_R_VALID_FALL, "fall valid", 32'h1);
    rec(5'd0, t, d);
    chk_rng("held rise time", rise0, rise0, t);
    rec(5'd1, t, d);
    chk("fall info", 32'h0000_0300, d);
    chk_rng("fall time", rise0 + 64'h1, sst, t);
    rc(`PTSC_R_IRQ_STAT, "stat", 32'h0000_000B);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`PTSC_R_IRQ_MASK, 32'h0000_0002);
    rc(`PTSC_R_DIAG_MISS, "missed count", 32'h1);
    chk("irq missed", 32'h1, {31'h0, irq});
    $display("hold test done");
    wr(`PTSC_R_ACK_RISE, 32'h0000_0001);
    rc(`PTSC_R_VALID_RISE, "rise acked", 32'h0);
    field_in <= 16'h0007;
    wait_prod(200, n);
    chk("rise valid pt1", 32'h2, {16'h0, produce_valid_rise});
    chk("missed pushed", 32'h1, {16'h0, produce_missed});
    rec(5'd2, t, d);
    chk("pt1 info", 32'h0000_0201, d);
    $display("ack test done");
    wr(`PTSC_R_RPI, 32'h0000_0001);
    wait_prod(UNIT + 1000, n);
    wait_prod(UNIT + 1000, n);
    chk_rng("interval", UNIT - 3, UNIT + 3, n);
    wr(`PTSC_R_RPI, 32'h0000_0000);
    $display("interval test done");
    chk("green", 32'h1, {31'h0, green});
    time_freeze <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rc(`PTSC_R_FAULT, "fault code", {24'h0, `PTSC_FLT_TIME});
    chk("red", 32'h1, {31'h0, red});
    time_freeze <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wr(`PTSC_R_CTRL, 32'h0000_0007);
    rc(`PTSC_R_FAULT, "fault cleared", 32'h0);
    chk("green again", 32'h1, {31'h0, green});
    link_en <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("green offline", 32'h0, {31'h0, green});
    $display("fault test done");
    stop_test();
  end
endmodule // ptsc_capture_test

bind ptsc_capture ptsc_capture_checker #(.NPTS(NPTS), .VENDOR_ID(VENDOR_ID)) u_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .field_in(field_in),
  .per_point_timestamp_mode(per_point_timestamp_mode), .link_up(link_up), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .produce_strobe(produce_strobe), .produce_inputs(produce_inputs), .produce_valid_rise(produce_valid_rise),
  .produce_valid_fall(produce_valid_fall), .produce_missed(produce_missed),
  .point_state_indicator(point_state_indicator), .module_health_red(module_health_red),
  .module_health_green(module_health_green), .irq(irq));
`default_nettype wire
